// ---- src/wpu_pkg.sv ----
// Purpose: constants and types shared by the write protect unit files.
// Assumes: 32-bit APB data, one register per aligned word, byte address = 4 * index.
// Notes: register indices are kept as printed; reserved bits read as zero.
package wpu_pkg;
    // core-side address layout
    localparam int ADDR_W = 20;
    localparam int BLK_MSB = 19;
    localparam int BLK_LSB = 16;
    localparam int SUB_MSB = 15;
    localparam int SUB_LSB = 12;
    localparam int SUB_W = 16;
    // apb side
    localparam int PADDR_W = 14;
    localparam int IDX_W = 12;
    localparam int NSEG = 2;
    // register indices (byte address is the index times four)
    localparam logic [IDX_W-1:0] IDX_SCOPE = 12'h440;
    localparam logic [IDX_W-1:0] IDX_LOWER = 12'h460;
    localparam logic [IDX_W-1:0] IDX_UPPER = 12'h461;
    localparam logic [IDX_W-1:0] IDX_SEG_SEL [NSEG] = '{12'h480, 12'h484};
    localparam logic [IDX_W-1:0] IDX_SEG_LO [NSEG] = '{12'h481, 12'h485};
    localparam logic [IDX_W-1:0] IDX_SEG_HI [NSEG] = '{12'h482, 12'h486};
    localparam logic [IDX_W-1:0] IDX_STATUS = 12'h490;
    // field positions and reset values
    localparam int SCOPE_BIT = 0;
    localparam int STAT_VALID_BIT = 31;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [1:0] IRQ_PRIO = 2'h3;
    // apb answer state
    typedef enum logic [1:0] {
        WPU_IDLE = 2'b01,
        WPU_ACK = 2'b10
    } wpu_apb_st_t;
endpackage

// ---- src/wpu_seg_if.sv ----
// Purpose: carries one segment's settings and the core address to its checker.
// Assumes: the checker is purely combinational.
// Notes: sub holds the upper enables in 15:8 and the lower ones in 7:0.
`timescale 1ns/100ps
interface wpu_seg_if;
    logic [3:0] sel;
    logic [wpu_pkg::SUB_W-1:0] sub;
    logic [wpu_pkg::ADDR_W-1:0] addr;
    logic hit;
    logic prot;
    modport cfg (output sel, sub, addr, input hit, prot);
    modport chk (input sel, sub, addr, output hit, prot);
endinterface

// ---- src/wpu_seg_check.sv ----
// Purpose: decides whether an address falls in a protected 4 KB piece of one segment.
// Assumes: sel already stripped of its reserved bits.
// Notes: no state; the top gates the result with the scope setting.
`timescale 1ns/100ps
module wpu_seg_check
(
    // segment settings and address
    wpu_seg_if.chk port
);
    import wpu_pkg::*;

    // segment match on the 64 KB block number
    assign port.hit = (port.sel == port.addr[BLK_MSB:BLK_LSB]);
    // [R06] [R07] 4 KB enable picked by address bits 15:12
    assign port.prot = port.hit & port.sub[port.addr[SUB_MSB:SUB_LSB]];
endmodule

// ---- src/wpu_top.sv ----
// Purpose: write protect unit watching core writes on a 20-bit physical bus.
// Assumes: core signals synchronous to pclk; APB slave with one wait-free access phase.
// Notes: protected writes are dropped combinationally and flagged one cycle later while ce is high.
// Summary of operation
// [R01] upper register bit n guards 64 KB block n+8
// [R02] cleared upper bit gives no block guard there
// [R03] each segment matches its 4-bit select against address bits 19:16
// [R04] matched segment guarded per 4 KB by lower and upper enable registers
// [R05] software writes zeros to select bits 7:4
// [R06] segment lower bit n guards 4 KB piece n of the segment
// [R07] cleared lower bit gives no 4 KB guard there
// [R08] lower register bit n guards 64 KB block n
// [R09] scope bit zero guards user mode only, one guards both modes
// [R10] a blocked write raises a priority 3 interrupt request
// [R11] block or segment guard plus scope blocks the write
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module wpu_top
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wpu_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core write path
    input wire logic [wpu_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_we,
    input wire logic cpu_user_mode,
    output logic mem_we,
    // interrupt request
    output logic wp_irq_req,
    output logic [1:0] wp_irq_prio
);
    import wpu_pkg::*;

    function automatic logic is_reg(input logic [PADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
        return a == {idx, 2'b00};
    endfunction

    logic scope_q, scope_d;
    logic [7:0] lower_q, lower_d, upper_q, upper_d;
    logic [3:0] seg_sel_q [NSEG];
    logic [3:0] seg_sel_d [NSEG];
    logic [7:0] seg_lo_q [NSEG];
    logic [7:0] seg_lo_d [NSEG];
    logic [7:0] seg_hi_q [NSEG];
    logic [7:0] seg_hi_d [NSEG];
    logic [SUB_W-1:0] seg_sub [NSEG];
    logic viol_valid_q, viol_valid_d;
    logic [ADDR_W-1:0] viol_addr_q, viol_addr_d;
    logic irq_q, irq_d;
    logic [31:0] prdata_q, prdata_d, rd;
    logic mapped;
    wpu_apb_st_t st_q, st_d;
    logic [NSEG-1:0] seg_prot;
    logic [15:0] blk_en;
    logic blk_prot, scope_ok, viol, wr_en;

    // one checker per segment
    genvar s;
    generate
        for (s = 0; s < NSEG; s++)
        begin : g_seg
            wpu_seg_if sif ();
            assign seg_sub[s] = {seg_hi_q[s], seg_lo_q[s]};
            assign sif.sel = seg_sel_q[s];
            assign sif.sub = seg_sub[s];
            assign sif.addr = cpu_addr;
            // [R03] [R04] segment 4 KB guard
            assign seg_prot[s] = sif.prot;
            wpu_seg_check u_chk (.port(sif.chk));
        end
    endgenerate

    // [R01] [R02] [R08] 64 KB guard, lower register below upper
    assign blk_en = {upper_q, lower_q};
    assign blk_prot = blk_en[cpu_addr[BLK_MSB:BLK_LSB]];
    // [R09] scope: user writes always checked, system ones only if bit set
    assign scope_ok = scope_q | cpu_user_mode;
    // [R11] protected write is dropped
    assign viol = cpu_we & scope_ok & (blk_prot | (|seg_prot));
    assign mem_we = cpu_we & ~viol;

    // apb handshake; pready gated by ce so a frozen block never completes
    assign wr_en = pready & pwrite;
    assign pready = psel & penable & ce & (st_q == WPU_ACK);
    assign pslverr = pready & ~mapped;
    assign prdata = prdata_q;
    assign wp_irq_req = irq_q;
    assign wp_irq_prio = IRQ_PRIO; // fixed level

    // read mux and map decode
    always_comb
    begin
        rd = '0;
        mapped = 1'b0;
        if (is_reg(paddr, IDX_SCOPE))
        begin
            rd[SCOPE_BIT] = scope_q;
            mapped = 1'b1;
        end
        if (is_reg(paddr, IDX_LOWER))
        begin
            rd[7:0] = lower_q;
            mapped = 1'b1;
        end
        if (is_reg(paddr, IDX_UPPER))
        begin
            rd[7:0] = upper_q;
            mapped = 1'b1;
        end
        for (int i = 0; i < NSEG; i++)
        begin
            if (is_reg(paddr, IDX_SEG_SEL[i]))
            begin
                rd[3:0] = seg_sel_q[i]; // reserved 7:4 read zero
                mapped = 1'b1;
            end
            if (is_reg(paddr, IDX_SEG_LO[i]))
            begin
                rd[7:0] = seg_lo_q[i];
                mapped = 1'b1;
            end
            if (is_reg(paddr, IDX_SEG_HI[i]))
            begin
                rd[7:0] = seg_hi_q[i];
                mapped = 1'b1;
            end
        end
        if (is_reg(paddr, IDX_STATUS))
        begin
            rd[STAT_VALID_BIT] = viol_valid_q;
            rd[ADDR_W-1:0] = viol_addr_q;
            mapped = 1'b1;
        end
    end

    // next state of registers, status and bus answer
    always_comb
    begin
        scope_d = scope_q;
        lower_d = lower_q;
        upper_d = upper_q;
        seg_sel_d = seg_sel_q;
        seg_lo_d = seg_lo_q;
        seg_hi_d = seg_hi_q;
        viol_valid_d = viol_valid_q;
        viol_addr_d = viol_addr_q;
        prdata_d = prdata_q;
        st_d = st_q;
        if (wr_en)
        begin
            if (is_reg(paddr, IDX_SCOPE))
                scope_d = pwdata[SCOPE_BIT];
            if (is_reg(paddr, IDX_LOWER))
                lower_d = pwdata[7:0];
            if (is_reg(paddr, IDX_UPPER))
                upper_d = pwdata[7:0];
            for (int i = 0; i < NSEG; i++)
            begin
                // [R05] reserved select bits are not stored
                if (is_reg(paddr, IDX_SEG_SEL[i]))
                    seg_sel_d[i] = pwdata[3:0];
                if (is_reg(paddr, IDX_SEG_LO[i]))
                    seg_lo_d[i] = pwdata[7:0];
                if (is_reg(paddr, IDX_SEG_HI[i]))
                    seg_hi_d[i] = pwdata[7:0];
            end
            if (is_reg(paddr, IDX_STATUS))
                viol_valid_d = 1'b0;
        end
        // a new violation beats a clear in the same cycle
        if (viol)
        begin
            viol_valid_d = 1'b1;
            viol_addr_d = cpu_addr;
        end
        // [R10] one request pulse per blocked write cycle
        irq_d = viol;
        unique case (st_q)
            WPU_IDLE:
            begin
                if (psel)
                begin
                    prdata_d = rd; // data sampled early so prdata is a flop
                    st_d = WPU_ACK;
                end
            end
            WPU_ACK:
                st_d = WPU_IDLE;
        endcase
    end

    // register stage, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scope_q <= 1'b0;
            lower_q <= RST_BYTE;
            upper_q <= RST_BYTE;
            for (int i = 0; i < NSEG; i++)
            begin
                seg_sel_q[i] <= RST_SEL;
                seg_lo_q[i] <= RST_BYTE;
                seg_hi_q[i] <= RST_BYTE;
            end
            viol_valid_q <= 1'b0;
            viol_addr_q <= '0;
            irq_q <= 1'b0;
            prdata_q <= '0;
            st_q <= WPU_IDLE;
        end
        else if (ce)
        begin
            scope_q <= scope_d;
            lower_q <= lower_d;
            upper_q <= upper_d;
            seg_sel_q <= seg_sel_d;
            seg_lo_q <= seg_lo_d;
            seg_hi_q <= seg_hi_d;
            viol_valid_q <= viol_valid_d;
            viol_addr_q <= viol_addr_d;
            irq_q <= irq_d;
            prdata_q <= prdata_d;
            st_q <= st_d;
        end
    end

    // checks
    sequence s_wr_lower;
        psel && penable && pready && pwrite && is_reg(paddr, IDX_LOWER);
    endsequence
    sequence s_blocked;
        ce && cpu_we && !mem_we;
    endsequence

    property p_blk_hi;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && cpu_addr[BLK_MSB] && upper_q[cpu_addr[BLK_MSB-1:BLK_LSB]] && scope_ok |-> !mem_we;
    endproperty
    a_blk_hi: assert property (p_blk_hi) else $error("upper block write passed"); // [R01]

    property p_blk_off;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && cpu_addr[BLK_MSB] && !upper_q[cpu_addr[BLK_MSB-1:BLK_LSB]] && !(|seg_prot)
            |-> mem_we;
    endproperty
    a_blk_off: assert property (p_blk_off) else $error("unguarded upper write dropped"); // [R02]

    property p_blk_lo;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && !cpu_addr[BLK_MSB] && lower_q[cpu_addr[BLK_MSB-1:BLK_LSB]] && scope_ok |-> !mem_we;
    endproperty
    a_blk_lo: assert property (p_blk_lo) else $error("lower block write passed"); // [R08]

    property p_lo_store;
        @(posedge pclk) disable iff (!presetn)
        s_wr_lower |=> lower_q == $past(pwdata[7:0]);
    endproperty
    a_lo_store: assert property (p_lo_store) else $error("lower register not stored"); // [R08]

    property p_seg_b;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && seg_sel_q[1] == cpu_addr[BLK_MSB:BLK_LSB]
            && seg_sub[1][cpu_addr[SUB_MSB:SUB_LSB]] && scope_ok |-> !mem_we;
    endproperty
    a_seg_b: assert property (p_seg_b) else $error("segment b write passed"); // [R03]

    property p_seg_a_lo;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && seg_sel_q[0] == cpu_addr[BLK_MSB:BLK_LSB] && !cpu_addr[SUB_MSB]
            && seg_lo_q[0][cpu_addr[SUB_MSB-1:SUB_LSB]] && scope_ok |-> !mem_we;
    endproperty
    a_seg_a_lo: assert property (p_seg_a_lo) else $error("segment a piece passed"); // [R06]

    property p_free;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && !blk_prot && !(|seg_prot) |-> mem_we;
    endproperty
    a_free: assert property (p_free) else $error("free write dropped"); // [R07]

    property p_scope;
        @(posedge pclk) disable iff (!presetn)
        cpu_we && !scope_q && !cpu_user_mode |-> mem_we;
    endproperty
    a_scope: assert property (p_scope) else $error("system write dropped"); // [R09]

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        s_blocked |=> wp_irq_req && wp_irq_prio == IRQ_PRIO;
    endproperty
    a_irq: assert property (p_irq) else $error("no request after block"); // [R10]

    property p_stat;
        @(posedge pclk) disable iff (!presetn)
        s_blocked |=> viol_valid_q && viol_addr_q == $past(cpu_addr);
    endproperty
    a_stat: assert property (p_stat) else $error("status not captured"); // [R11]
endmodule

// ---- test/wpu_core_model.sv ----
// Purpose: stand-in for the core that issues physical memory writes.
// Assumes: the bench asks for one write cycle at a time.
// Notes: idle cycles show an inverted address so stale values never look valid.
`timescale 1ns/100ps
module wpu_core_model
(
    // core write path
    output logic [wpu_pkg::ADDR_W-1:0] cpu_addr,
    output logic cpu_we,
    output logic cpu_user_mode
);
    import wpu_pkg::*;
    // quiet bus at time zero
    initial
    begin
        cpu_addr = '0;
        cpu_we = 1'b0;
        cpu_user_mode = 1'b0;
    end
    // one write cycle, or idle with a scrambled address
    task drive(input logic [ADDR_W-1:0] a, input logic u, input logic we);
        cpu_addr <= we ? a : ~a;
        cpu_user_mode <= u;
        cpu_we <= we;
    endtask
endmodule

// ---- test/test_physical_write_protect_unit.sv ----
// Purpose: self-checking bench for the write protect unit.
// Assumes: clock enable low only in the freeze scenario; byte address is index times four.
// Notes: every register access waits for pready under a bounded count.
`timescale 1ns/100ps
module test_physical_write_protect_unit;
    import wpu_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [ADDR_W-1:0] cpu_addr;
    logic cpu_we;
    logic cpu_user_mode;
    logic mem_we;
    logic wp_irq_req;
    logic [1:0] wp_irq_prio;
    logic [31:0] rd;
    logic serr;
    logic [15:0] m;
    int err_count = 0;
    int checks_done = 0;
    logic [IDX_W-1:0] ridx [5] = '{IDX_UPPER, IDX_SEG_SEL[0], IDX_SEG_LO[0],
        IDX_SEG_SEL[1], IDX_SEG_LO[1]};
    // 100 ns clock
    always #50 pclk = ~pclk;
    wpu_top DUT
    (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_user_mode(cpu_user_mode),
        .mem_we(mem_we), .wp_irq_req(wp_irq_req), .wp_irq_prio(wp_irq_prio)
    );
    wpu_core_model cpu
    (
        .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_user_mode(cpu_user_mode)
    );
    // verdict and end of run
    task stop_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // single compare for all values
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            stop_test;
        end
        else
        begin
            rd = prdata;
            serr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        cmp(rd, exp);
    endtask
    // one core write, the request pulse a cycle later, then the pulse gone
    task core(input logic [ADDR_W-1:0] a, input logic u, input logic blk);
        @(posedge pclk);
        cpu.drive(a, u, 1'b1);
        #50 cmp(mem_we, !blk);
        @(posedge pclk);
        cpu.drive(a, u, 1'b0);
        #50 cmp(wp_irq_req, blk);
        @(posedge pclk);
        #50 cmp(wp_irq_req, 1'b0);
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ridx[i]) rchk(ridx[i], 32'h0);
        apb(1'b1, IDX_UPPER, 32'h5a);
        rchk(IDX_UPPER, 32'h5a);
        apb(1'b1, IDX_SEG_SEL[0], 32'hc);
        rchk(IDX_SEG_SEL[0], 32'hc);
        // unmapped place is refused and reads zero
        apb(1'b0, 12'h4ff, 32'h0);
        cmp(serr, 1'b1);
        cmp(rd, 32'h0);
        // walk one enable over all sixteen 64 KB blocks
        for (int n = 0; n < 16; n++)
        begin
            m = 16'h1 << n;
            apb(1'b1, IDX_LOWER, {24'h0, m[7:0]});
            apb(1'b1, IDX_UPPER, {24'h0, m[15:8]});
            core({n[3:0], 16'h8abc}, 1'b1, 1'b1);
            core({n[3:0] + 4'h1, 16'h8abc}, 1'b1, 1'b0);
        end
        apb(1'b1, IDX_UPPER, 32'h0);
        // walk one enable over the lower eight 4 KB pieces of segment a
        for (int n = 0; n < 8; n++)
        begin
            apb(1'b1, IDX_SEG_LO[0], {24'h0, 8'h1 << n});
            core({4'hc, 1'b0, n[2:0], 12'h123}, 1'b1, 1'b1);
            core({4'hc, 1'b0, n[2:0] + 3'h1, 12'h123}, 1'b1, 1'b0);
            core({4'hd, 1'b0, n[2:0], 12'h123}, 1'b1, 1'b0);
        end
        // upper half of segment a through its high enables
        apb(1'b1, IDX_SEG_HI[0], 32'h1);
        core(20'hc8000, 1'b1, 1'b1);
        core(20'hc9000, 1'b1, 1'b0);
        apb(1'b1, IDX_SEG_HI[0], 32'h0);
        // segment b on its own block
        apb(1'b1, IDX_SEG_SEL[1], 32'h2);
        apb(1'b1, IDX_SEG_LO[1], 32'h1);
        core(20'h20000, 1'b1, 1'b1);
        core(20'h21000, 1'b1, 1'b0);
        // system mode is exempt until the scope bit is set
        core(20'h20000, 1'b0, 1'b0);
        apb(1'b1, IDX_SCOPE, 32'h1);
        core(20'h20000, 1'b0, 1'b1);
        // status keeps the last blocked address; a write clears valid only
        rchk(IDX_STATUS, 32'h80020000);
        apb(1'b1, IDX_STATUS, 32'h0);
        rchk(IDX_STATUS, 32'h00020000);
        // frozen block still drops the write but records nothing
        @(posedge pclk);
        ce <= 1'b0;
        cpu.drive(20'h20000, 1'b0, 1'b1);
        #50 cmp(mem_we, 1'b0);
        @(posedge pclk);
        cpu.drive(20'h20000, 1'b0, 1'b0);
        #50 cmp(wp_irq_req, 1'b0);
        @(posedge pclk);
        ce <= 1'b1;
        rchk(IDX_STATUS, 32'h00020000);
        // reset in mid-run brings every setting back to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(IDX_SCOPE, 32'h0);
        rchk(IDX_SEG_SEL[1], 32'h0);
        rchk(IDX_STATUS, 32'h0);
        core(20'h20000, 1'b1, 1'b0);
        cmp(wp_irq_prio, 2'h3);
        stop_test;
    end
endmodule
